// >>> logic/esf_pkg.sv
// package for the eeprom sector erase and memory interrupt block
package esf_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int GADDR_W = 18;

  // register word addresses
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CONFIG = 4'h1;
  localparam logic [3:0] REG_ECC_STATUS = 4'h2;
  localparam logic [3:0] REG_ECC_CONFIG = 4'h3;
  localparam logic [3:0] REG_PARAM_INDEX = 4'h4;
  localparam logic [3:0] REG_PARAM_DATA = 4'h5;
  localparam logic [3:0] REG_PROTECT = 4'h6;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h7;
  localparam logic [3:0] REG_IRQ_MASK = 4'h8;

  // status register bit positions
  localparam int ST_CCF = 7;
  localparam int ST_ACC = 5;
  localparam int ST_PV = 4;
  localparam int ST_VANY = 1;
  localparam int ST_VUNC = 0;
  // config and ecc bit positions
  localparam int CF_CMD_COMPLETE_IRQ_ENABLE = 7;
  localparam int EC_DF = 1;
  localparam int EC_SF = 0;
  // protect register
  localparam int PR_OPEN = 7;
  localparam int PR_SIZE_W = 5;

  // irq status bits: 0 done, 1 double fault, 2 single fault
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_DF = 1;
  localparam int IRQ_SF = 2;

  localparam logic [7:0] CMD_ERASE_SECTOR = 8'h12;
  localparam logic [2:0] PIDX_LAST = 3'h1;
  localparam int NPARAM = 2;

  // eeprom range and protection window
  localparam logic [17:0] EE_BASE = 18'h00400;
  localparam logic [17:0] EE_LAST = 18'h013ff;
  localparam logic [17:0] PROT_BASE = 18'h00400;
  localparam logic [17:0] PROT_STEP = 18'h00020;
  localparam int SECTOR_SHIFT = 2;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  typedef enum logic [1:0] {
    ESF_IDLE,
    ESF_ERASE,
    ESF_VERIFY
  } esf_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } esf_bus_req_t;

  typedef struct packed {
    logic double_fault;
    logic single_fault;
  } esf_ecc_t;
endpackage

// >>> logic/esf_mem.sv
// eeprom array model with registered read and ecc fault tags
`timescale 1ns/100ps
module esf_mem #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic [1:0] wfault,
  output logic [DW-1:0] rdata,
  output logic [1:0] rfault
);
  logic [DW-1:0] mem [2**AW];
  logic [1:0] flt [2**AW];

  // ecc tags are injected by the writer so faults can be exercised
  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[addr] <= wdata;
        flt[addr] <= wfault;
      end
      rdata <= mem[addr];
      rfault <= flt[addr];
    end
  end
endmodule

// >>> logic/esf_top.sv
// Function
// - clearing completion flag launches erase of whole sector then verify
// - completion flag sets again only after erase and verify finish
// - access error at launch if parameter index is not 001
// - access error at launch if command not allowed in current mode
// - access error at launch if 18-bit address outside valid range
// - access error at launch if address bit 0 is set
// - protection violation at launch if sector lies in protected area
// - verify-any bit set on any error during verify
// - verify-uncorrectable bit set on non-correctable error during verify
// - completion interrupt from completion flag gated by its enable
// - double-bit ecc fault on read sets flag, interrupts when enabled
// - single-bit ecc fault on read sets flag, interrupts when enabled
// - protected region starts 0x400, grows 32 bytes per size step
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/100ps
module esf_top #(
  parameter int MEM_AW = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [esf_pkg::ADDR_W-1:0] addr,
  input wire logic [esf_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [esf_pkg::DATA_W-1:0] rdata,
  input wire logic cmd_allowed,
  input wire logic [1:0] read_fault,
  input wire logic read_valid,
  output logic cmd_complete_irq,
  output logic double_fault_irq,
  output logic single_fault_irq,
  output logic irq
);
  localparam int SEC_BYTES = 1 << esf_pkg::SECTOR_SHIFT;

  typedef struct packed {
    esf_pkg::esf_state_t st;
    logic cmd_complete_flag;
    logic access_error_flag;
    logic protection_violation_flag;
    logic verify_any_error_bit;
    logic verify_uncorrectable_bit;
    logic cmd_complete_irq_enable;
    logic double_fault_flag;
    logic single_fault_flag;
    logic double_fault_irq_enable;
    logic single_fault_irq_enable;
    logic [2:0] param_word_index;
    logic [esf_pkg::DATA_W-1:0] pw0;
    logic [esf_pkg::DATA_W-1:0] pw1;
    logic eeprom_protect_open;
    logic [esf_pkg::PR_SIZE_W-1:0] eeprom_protect_size;
    logic [esf_pkg::IRQ_W-1:0] irq_stat;
    logic [esf_pkg::IRQ_W-1:0] irq_mask;
    logic [esf_pkg::GADDR_W-1:0] base;
    logic [esf_pkg::SECTOR_SHIFT-1:0] ofs;
    logic chk;
    logic [esf_pkg::DATA_W-1:0] rdata;
    logic cc_irq;
    logic df_irq;
    logic sf_irq;
    logic irq;
  } esf_regs_t;

  // reset image; completion flag starts set so the first launch is taken
  localparam esf_regs_t REGS_RESET = '{
    st: esf_pkg::ESF_IDLE,
    cmd_complete_flag: 1'b1,
    access_error_flag: 1'b0,
    protection_violation_flag: 1'b0,
    verify_any_error_bit: 1'b0,
    verify_uncorrectable_bit: 1'b0,
    cmd_complete_irq_enable: 1'b0,
    double_fault_flag: 1'b0,
    single_fault_flag: 1'b0,
    double_fault_irq_enable: 1'b0,
    single_fault_irq_enable: 1'b0,
    param_word_index: '0,
    pw0: '0,
    pw1: '0,
    eeprom_protect_open: 1'b0,
    eeprom_protect_size: '0,
    irq_stat: '0,
    irq_mask: '0,
    base: '0,
    ofs: '0,
    chk: 1'b0,
    rdata: '0,
    cc_irq: 1'b0,
    df_irq: 1'b0,
    sf_irq: 1'b0,
    irq: 1'b0
  };

  esf_regs_t r_q;
  esf_regs_t r_d;
  esf_pkg::esf_bus_req_t bus;
  esf_pkg::esf_ecc_t rf_s1_q;
  esf_pkg::esf_ecc_t rf_s2_q;
  logic rv_s1_q;
  logic rv_s2_q;
  logic [7:0] m_rdata;
  logic [1:0] m_rfault;
  logic m_we;
  logic [MEM_AW-1:0] m_addr;
  logic [esf_pkg::GADDR_W-1:0] gaddr;
  logic [esf_pkg::GADDR_W-1:0] prot_end;
  logic bad_idx;
  logic bad_addr;
  logic bad_align;
  logic prot_hit;
  logic launch;
  logic launch_err;

  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  function automatic logic in_range(input logic [esf_pkg::GADDR_W-1:0] a,
                                    input logic [esf_pkg::GADDR_W-1:0] lo,
                                    input logic [esf_pkg::GADDR_W-1:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // fault pins come from the read path domain; two stages before use
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rf_s1_q <= '0;
      rf_s2_q <= '0;
      rv_s1_q <= 1'b0;
      rv_s2_q <= 1'b0;
    end else if (ce) begin
      rf_s1_q <= esf_pkg::esf_ecc_t'(read_fault);
      rf_s2_q <= rf_s1_q;
      rv_s1_q <= read_valid;
      rv_s2_q <= rv_s1_q;
    end
  end

  assign gaddr = {r_q.pw0[1:0], r_q.pw1};
  assign prot_end = esf_pkg::PROT_BASE +
    esf_pkg::PROT_STEP * (esf_pkg::GADDR_W'(r_q.eeprom_protect_size) + 18'h1) - 18'h1;
  assign bad_idx = r_q.param_word_index != esf_pkg::PIDX_LAST ||
    r_q.pw0[15:8] != esf_pkg::CMD_ERASE_SECTOR;
  assign bad_addr = !in_range(gaddr, esf_pkg::EE_BASE, esf_pkg::EE_LAST);
  assign bad_align = gaddr[0];
  assign prot_hit = r_q.eeprom_protect_open && in_range(gaddr, esf_pkg::PROT_BASE, prot_end);
  assign launch_err = bad_idx || !cmd_allowed || bad_addr || bad_align ||
    prot_hit;
  assign launch = bus.wr && bus.addr == esf_pkg::REG_STATUS && bus.wdata[esf_pkg::ST_CCF] &&
    r_q.cmd_complete_flag && r_q.st == esf_pkg::ESF_IDLE;

  assign m_we = r_q.st == esf_pkg::ESF_ERASE;
  // upper bits of the given address pick the sector, offset walks its bytes
  assign m_addr = MEM_AW'(({r_q.base[esf_pkg::GADDR_W-1:esf_pkg::SECTOR_SHIFT], r_q.ofs})
    - esf_pkg::EE_BASE);

  // array fault tags tied low; faults reach the verify through the fault pins
  esf_mem #(.AW(MEM_AW), .DW(8)) u_mem (
    .clk(clk),
    .ce(ce),
    .we(m_we),
    .addr(m_addr),
    .wdata(esf_pkg::ERASED_BYTE),
    .wfault(2'b00),
    .rdata(m_rdata),
    .rfault(m_rfault)
  );

  always_comb begin
    // one-cycle event pulses into the irq status
    logic [esf_pkg::IRQ_W-1:0] ev;
    ev = '0;
    r_d = r_q;
    r_d.rdata = '0;
    if (bus.rd) begin
      if (bus.addr == esf_pkg::REG_STATUS) begin
        r_d.rdata[esf_pkg::ST_CCF] = r_q.cmd_complete_flag;
        r_d.rdata[esf_pkg::ST_ACC] = r_q.access_error_flag;
        r_d.rdata[esf_pkg::ST_PV] = r_q.protection_violation_flag;
        r_d.rdata[esf_pkg::ST_VANY] = r_q.verify_any_error_bit;
        r_d.rdata[esf_pkg::ST_VUNC] = r_q.verify_uncorrectable_bit;
      end else if (bus.addr == esf_pkg::REG_CONFIG) begin
        r_d.rdata[esf_pkg::CF_CMD_COMPLETE_IRQ_ENABLE] = r_q.cmd_complete_irq_enable;
      end else if (bus.addr == esf_pkg::REG_ECC_STATUS) begin
        r_d.rdata[esf_pkg::EC_DF] = r_q.double_fault_flag;
        r_d.rdata[esf_pkg::EC_SF] = r_q.single_fault_flag;
      end else if (bus.addr == esf_pkg::REG_ECC_CONFIG) begin
        r_d.rdata[esf_pkg::EC_DF] = r_q.double_fault_irq_enable;
        r_d.rdata[esf_pkg::EC_SF] = r_q.single_fault_irq_enable;
      end else if (bus.addr == esf_pkg::REG_PARAM_INDEX) begin
        r_d.rdata[2:0] = r_q.param_word_index;
      end else if (bus.addr == esf_pkg::REG_PARAM_DATA) begin
        r_d.rdata = r_q.param_word_index[0] ? r_q.pw1 : r_q.pw0;
      end else if (bus.addr == esf_pkg::REG_PROTECT) begin
        r_d.rdata[esf_pkg::PR_OPEN] = r_q.eeprom_protect_open;
        r_d.rdata[esf_pkg::PR_SIZE_W-1:0] = r_q.eeprom_protect_size;
      end else if (bus.addr == esf_pkg::REG_IRQ_STATUS) begin
        r_d.rdata[esf_pkg::IRQ_W-1:0] = r_q.irq_stat;
      end else if (bus.addr == esf_pkg::REG_IRQ_MASK) begin
        r_d.rdata[esf_pkg::IRQ_W-1:0] = r_q.irq_mask;
      end
    end
    if (bus.wr) begin
      if (bus.addr == esf_pkg::REG_STATUS) begin
        // error flags are write-one-to-clear
        if (bus.wdata[esf_pkg::ST_ACC]) r_d.access_error_flag = 1'b0;
        if (bus.wdata[esf_pkg::ST_PV]) r_d.protection_violation_flag = 1'b0;
      end else if (bus.addr == esf_pkg::REG_CONFIG) begin
        r_d.cmd_complete_irq_enable = bus.wdata[esf_pkg::CF_CMD_COMPLETE_IRQ_ENABLE];
      end else if (bus.addr == esf_pkg::REG_ECC_STATUS) begin
        if (bus.wdata[esf_pkg::EC_DF]) r_d.double_fault_flag = 1'b0;
        if (bus.wdata[esf_pkg::EC_SF]) r_d.single_fault_flag = 1'b0;
      end else if (bus.addr == esf_pkg::REG_ECC_CONFIG) begin
        r_d.double_fault_irq_enable = bus.wdata[esf_pkg::EC_DF];
        r_d.single_fault_irq_enable = bus.wdata[esf_pkg::EC_SF];
      end else if (bus.addr == esf_pkg::REG_PARAM_INDEX) begin
        r_d.param_word_index = bus.wdata[2:0];
      end else if (bus.addr == esf_pkg::REG_PARAM_DATA) begin
        // parameters only change while idle to keep the running address stable
        if (r_q.cmd_complete_flag && r_q.param_word_index == 3'h0) r_d.pw0 = bus.wdata;
        if (r_q.cmd_complete_flag && r_q.param_word_index == esf_pkg::PIDX_LAST) r_d.pw1 = bus.wdata;
      end else if (bus.addr == esf_pkg::REG_PROTECT) begin
        r_d.eeprom_protect_open = bus.wdata[esf_pkg::PR_OPEN];
        r_d.eeprom_protect_size = bus.wdata[esf_pkg::PR_SIZE_W-1:0];
      end else if (bus.addr == esf_pkg::REG_IRQ_STATUS) begin
        // set beats clear: events are or'ed in after this
        r_d.irq_stat = r_q.irq_stat & ~bus.wdata[esf_pkg::IRQ_W-1:0];
      end else if (bus.addr == esf_pkg::REG_IRQ_MASK) begin
        r_d.irq_mask = bus.wdata[esf_pkg::IRQ_W-1:0];
      end
    end

    case (r_q.st)
      esf_pkg::ESF_IDLE: begin
        if (launch) begin
          r_d.verify_any_error_bit = 1'b0;
          r_d.verify_uncorrectable_bit = 1'b0;
          if (bad_idx || !cmd_allowed || bad_addr || bad_align) begin
            r_d.access_error_flag = 1'b1;
          end
          if (prot_hit) begin
            r_d.protection_violation_flag = 1'b1;
          end
          if (launch_err) begin
            r_d.cmd_complete_flag = 1'b1;
          end else begin
            r_d.cmd_complete_flag = 1'b0;
            r_d.base = gaddr;
            r_d.ofs = '0;
            r_d.st = esf_pkg::ESF_ERASE;
          end
        end
      end
      esf_pkg::ESF_ERASE: begin
        // one byte per cycle, so erase time follows the sector size
        if (ce) begin
          r_d.ofs = r_q.ofs + 1'b1;
          if (r_q.ofs == esf_pkg::SECTOR_SHIFT'(SEC_BYTES - 1)) begin
            r_d.st = esf_pkg::ESF_VERIFY;
            r_d.chk = 1'b0;
          end
        end
      end
      esf_pkg::ESF_VERIFY: begin
        if (ce) begin
          // read data lag one cycle behind the address
          r_d.chk = 1'b1;
          r_d.ofs = r_q.ofs + 1'b1;
          if (r_q.chk) begin
            if (m_rdata != esf_pkg::ERASED_BYTE || m_rfault != 2'b00) r_d.verify_any_error_bit = 1'b1;
            if (m_rfault[1]) r_d.verify_uncorrectable_bit = 1'b1;
          end
          // ecc fault on the read path while verifying
          if (rv_s2_q && (rf_s2_q.double_fault || rf_s2_q.single_fault)) begin
            r_d.verify_any_error_bit = 1'b1;
          end
          // double fault while verifying is uncorrectable
          if (rv_s2_q && rf_s2_q.double_fault) begin
            r_d.verify_uncorrectable_bit = 1'b1;
          end
          if (r_q.chk && r_q.ofs == '0) begin
            r_d.cmd_complete_flag = 1'b1;
            ev[esf_pkg::IRQ_DONE] = 1'b1;
            r_d.st = esf_pkg::ESF_IDLE;
          end
        end
      end
      default: r_d.st = esf_pkg::ESF_IDLE;
    endcase

    // double and single fault capture, set beats clear
    if (rv_s2_q && rf_s2_q.double_fault) begin
      r_d.double_fault_flag = 1'b1;
      ev[esf_pkg::IRQ_DF] = 1'b1;
    end
    if (rv_s2_q && rf_s2_q.single_fault) begin
      r_d.single_fault_flag = 1'b1;
      ev[esf_pkg::IRQ_SF] = 1'b1;
    end
    r_d.irq_stat = r_d.irq_stat | ev;

    r_d.cc_irq = r_d.cmd_complete_flag && r_d.cmd_complete_irq_enable;
    r_d.df_irq = r_d.double_fault_flag && r_d.double_fault_irq_enable;
    r_d.sf_irq = r_d.single_fault_flag && r_d.single_fault_irq_enable;
    r_d.irq = |(r_d.irq_stat & r_d.irq_mask);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_q <= REGS_RESET;
    end else if (ce) begin
      r_q <= r_d;
    end
  end

  // every output straight from the state register
  assign rdata = r_q.rdata;
  assign cmd_complete_irq = r_q.cc_irq;
  assign double_fault_irq = r_q.df_irq;
  assign single_fault_irq = r_q.sf_irq;
  assign irq = r_q.irq;
endmodule

// >>> test/esf_props.sv
// concurrent checks on the ports of the eeprom erase and interrupt block
`timescale 1ns/100ps
module esf_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [esf_pkg::ADDR_W-1:0] addr,
  input wire logic [esf_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [esf_pkg::DATA_W-1:0] rdata,
  input wire logic cmd_allowed,
  input wire logic [1:0] read_fault,
  input wire logic read_valid,
  input wire logic cmd_complete_irq,
  input wire logic double_fault_irq,
  input wire logic single_fault_irq,
  input wire logic irq
);
  logic cc_en_q;
  logic df_en_q;
  logic sf_en_q;
  // shadow of the enables, the registers are not visible here
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cc_en_q <= 1'b0;
      df_en_q <= 1'b0;
      sf_en_q <= 1'b0;
    end else if (ce && wr && addr == esf_pkg::REG_CONFIG) begin
      cc_en_q <= wdata[esf_pkg::CF_CMD_COMPLETE_IRQ_ENABLE];
    end else if (ce && wr && addr == esf_pkg::REG_ECC_CONFIG) begin
      df_en_q <= wdata[esf_pkg::EC_DF];
      sf_en_q <= wdata[esf_pkg::EC_SF];
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence quiet3;
    (ce && !wr)[*3];
  endsequence
  sequence launch_s;
    ce && wr && addr == esf_pkg::REG_STATUS && wdata[esf_pkg::ST_CCF] && cc_en_q;
  endsequence
  AST_DF_RAISE: assert property (read_valid && read_fault[1] && df_en_q && ce ##1 quiet3 |-> ##[1:2] double_fault_irq)
    else $error("double fault interrupt missing");
  AST_SF_RAISE: assert property (read_valid && read_fault[0] && sf_en_q && ce ##1 quiet3 |-> ##[1:2] single_fault_irq)
    else $error("single fault interrupt missing");
  AST_DF_GATED: assert property (!df_en_q && $past(!df_en_q) |-> !double_fault_irq)
    else $error("double fault interrupt without enable");
  AST_SF_GATED: assert property (!sf_en_q && $past(!sf_en_q) |-> !single_fault_irq)
    else $error("single fault interrupt without enable");
  AST_CC_GATED: assert property (!cc_en_q && $past(!cc_en_q) |-> !cmd_complete_irq)
    else $error("completion interrupt without enable");
  AST_DF_HOLD: assert property (double_fault_irq && df_en_q && !wr && !$past(wr) |=> double_fault_irq)
    else $error("double fault interrupt dropped by itself");
  AST_CC_RETURN: assert property (launch_s |-> ##[1:20] cmd_complete_irq)
    else $error("completion interrupt not back after launch");
  AST_RESET_QUIET: assert property ($past(!rst_n) |-> !irq && !cmd_complete_irq && !double_fault_irq)
    else $error("interrupt high right after reset");
endmodule

// >>> test/esf_top_tb.sv
// self-checking bench for the eeprom erase and interrupt block
`timescale 1ns/100ps
module esf_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic cmd_allowed = 1'b1;
  logic [1:0] read_fault = 2'h0;
  logic read_valid = 1'b0;
  logic cc_irq;
  logic df_irq;
  logic sf_irq;
  logic irq;
  int bad_count = 0;
  int compares = 0;
  logic [15:0] rv;

  esf_top u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cmd_allowed(cmd_allowed), .read_fault(read_fault), .read_valid(read_valid),
    .cmd_complete_irq(cc_irq), .double_fault_irq(df_irq), .single_fault_irq(sf_irq), .irq(irq));

  initial forever #5 clk = ~clk;

  task automatic tally_and_finish();
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string msg);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %b want %b", $time, msg, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic launch(input logic [2:0] idx, input logic [15:0] w0, input logic [15:0] w1);
    wr_reg(esf_pkg::REG_PARAM_INDEX, 16'h0000);
    wr_reg(esf_pkg::REG_PARAM_DATA, w0);
    wr_reg(esf_pkg::REG_PARAM_INDEX, 16'h0001);
    wr_reg(esf_pkg::REG_PARAM_DATA, w1);
    wr_reg(esf_pkg::REG_PARAM_INDEX, {13'h0000, idx});
    wr_reg(esf_pkg::REG_STATUS, 16'h0080);
  endtask

  task automatic t_reset();
    rd_reg(esf_pkg::REG_STATUS, rv);
    chk16(rv, 16'h0080, "status after reset");
    rd_reg(esf_pkg::REG_ECC_STATUS, rv);
    chk16(rv, 16'h0000, "ecc status after reset");
    rd_reg(4'hf, rv);
    chk16(rv, 16'h0000, "unmapped read");
    chk1(irq, 1'b0, "irq after reset");
  endtask

  task automatic t_erase_ok(input logic [15:0] w1);
    wr_reg(esf_pkg::REG_CONFIG, 16'h0080);
    wr_reg(esf_pkg::REG_IRQ_MASK, 16'h0001);
    launch(3'h1, 16'h1200, w1);
    rd_reg(esf_pkg::REG_STATUS, rv);
    chk16(rv, 16'h0000, "flag low while erasing");
    for (int i = 0; i < 40 && !rv[7]; i++) rd_reg(esf_pkg::REG_STATUS, rv);
    chk16(rv, 16'h0080, "clean finish");
    chk1(cc_irq, 1'b1, "completion interrupt");
    rd_reg(esf_pkg::REG_IRQ_STATUS, rv);
    chk16(rv, 16'h0001, "done event");
    chk1(irq, 1'b1, "summary irq");
    wr_reg(esf_pkg::REG_IRQ_STATUS, 16'h0007);
    wr_reg(esf_pkg::REG_CONFIG, 16'h0000);
    repeat (2) @(posedge clk);
    #1 chk1(cc_irq, 1'b0, "completion irq off");
    chk1(irq, 1'b0, "summary irq off");
  endtask

  task automatic t_erase_err(input logic [2:0] idx, input logic [15:0] w1, input logic ok, input logic [15:0] exp);
    cmd_allowed <= ok;
    launch(idx, 16'h1200, w1);
    rd_reg(esf_pkg::REG_STATUS, rv);
    chk16(rv, exp, "launch refused with error");
    wr_reg(esf_pkg::REG_STATUS, 16'h0030);
    cmd_allowed <= 1'b1;
  endtask

  task automatic pulse_fault(input logic [1:0] f);
    @(posedge clk);
    read_valid <= 1'b1;
    read_fault <= f;
    @(posedge clk);
    read_valid <= 1'b0;
    read_fault <= 2'h0;
    repeat (5) @(posedge clk);
  endtask

  task automatic t_ecc();
    wr_reg(esf_pkg::REG_ECC_CONFIG, 16'h0003);
    wr_reg(esf_pkg::REG_IRQ_MASK, 16'h0006);
    pulse_fault(2'h3);
    #1 chk1(df_irq, 1'b1, "double fault irq");
    chk1(sf_irq, 1'b1, "single fault irq");
    chk1(irq, 1'b1, "summary irq on fault");
    wr_reg(esf_pkg::REG_ECC_STATUS, 16'h0003);
    wr_reg(esf_pkg::REG_ECC_CONFIG, 16'h0002);
    pulse_fault(2'h1);
    #1 chk1(sf_irq, 1'b0, "masked single fault");
    chk1(df_irq, 1'b0, "double fault cleared");
    rd_reg(esf_pkg::REG_ECC_STATUS, rv);
    chk16(rv, 16'h0001, "single fault flag only");
    wr_reg(esf_pkg::REG_ECC_CONFIG, 16'h0003);
    repeat (2) @(posedge clk);
    #1 chk1(sf_irq, 1'b1, "late enable raises irq");
  endtask

  // ce low freezes the erase; read faults held through the verify
  task automatic t_erase_fault(input logic [1:0] f, input logic [15:0] exp);
    read_valid <= 1'b1;
    read_fault <= f;
    launch(3'h1, 16'h1200, 16'h0440);
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    rd_reg(esf_pkg::REG_STATUS, rv);
    chk16(rv, 16'h0000, "erase frozen while ce low");
    repeat (12) @(posedge clk);
    read_valid <= 1'b0;
    read_fault <= 2'h0;
    rd_reg(esf_pkg::REG_STATUS, rv);
    chk16(rv, exp, "verify status with read faults");
    wr_reg(esf_pkg::REG_ECC_STATUS, 16'h0003);
    wr_reg(esf_pkg::REG_IRQ_STATUS, 16'h0007);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    wr_reg(esf_pkg::REG_PROTECT, 16'h0080);
    t_erase_err(3'h0, 16'h0500, 1'b1, 16'h00a0);
    t_erase_err(3'h1, 16'h0500, 1'b0, 16'h00a0);
    t_erase_err(3'h1, 16'h1400, 1'b1, 16'h00a0);
    t_erase_err(3'h1, 16'h0501, 1'b1, 16'h00a0);
    t_erase_err(3'h1, 16'h041e, 1'b1, 16'h0090);
    t_erase_ok(16'h0420);
    wr_reg(esf_pkg::REG_PROTECT, 16'h0081);
    t_erase_err(3'h1, 16'h043e, 1'b1, 16'h0090);
    t_erase_ok(16'h13fe);
    t_erase_fault(2'h1, 16'h0082);
    t_erase_fault(2'h3, 16'h0083);
    t_ecc();
    tally_and_finish();
  end

  // far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
endmodule

bind esf_top esf_props u_props (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .cmd_allowed(cmd_allowed), .read_fault(read_fault), .read_valid(read_valid),
  .cmd_complete_irq(cmd_complete_irq), .double_fault_irq(double_fault_irq),
  .single_fault_irq(single_fault_irq), .irq(irq));
